// file: src/dlvts_params.svh
// Purpose: Constants of the dead line detector and VT supervision block
// Assumes: 50 MHz sys_clk; magnitudes in 0.01 % of nominal
// Notes:   Register map, field positions, reset values and timing
`ifndef DLVTS_PARAMS_SVH
`define DLVTS_PARAMS_SVH

// Register offsets
`define DLVTS_ADDR_CTRL   4'h0
`define DLVTS_ADDR_DTHR   4'h4
`define DLVTS_ADDR_VTHR   4'h8
`define DLVTS_ADDR_STAT   4'hc

// Field positions
`define DLVTS_CTRL_EN     0
`define DLVTS_CTRL_MODE   1
`define DLVTS_DTHR_U      0
`define DLVTS_DTHR_I      16
`define DLVTS_VTHR_U      0
`define DLVTS_VTHR_I0     8
`define DLVTS_VTHR_I2     16
`define DLVTS_PCT_W       7
`define DLVTS_STAT_PAD    21

// Reset values and ranges in percent
`define DLVTS_DLD_U_DEF   7'h3c
`define DLVTS_DLD_I_DEF   7'h0a
`define DLVTS_VTS_U_DEF   7'h1e
`define DLVTS_VTS_I0_DEF  7'h0a
`define DLVTS_VTS_I2_DEF  7'h0a
`define DLVTS_DLD_U_MIN   7'h0a
`define DLVTS_DLD_I_MIN   7'h02
`define DLVTS_VTS_MIN     7'h01
`define DLVTS_PCT_MAX     7'h64

// Pickup and dropout multipliers per percent
`define DLVTS_PICK_MUL    24'h000064
`define DLVTS_DROP_MUL    24'h00005f

// Timing
`define DLVTS_TMR_W       24
`define DLVTS_CLK_HZ      50000000
`define DLVTS_ARM_MS      200
`define DLVTS_COND_MS     4
`define DLVTS_REL_MS      200
`define DLVTS_LATCH_MS    100

`endif

// file: src/dlvts_pkg.sv
// Purpose: Types of the dead line detector and VT supervision block
// Assumes: Nothing beyond the params header
// Notes:   Measurement and status carriers
package dlvts_pkg;

  typedef enum logic [1:0] {
    DLVTS_MODE_ZERO,
    DLVTS_MODE_NEG,
    DLVTS_MODE_SPECIAL
  } dlvts_mode_t;

  typedef struct packed {
    logic [2:0][15:0] phase_voltage;
    logic [2:0][15:0] phase_current;
    logic [15:0]      residual_voltage;
    logic [15:0]      residual_current;
    logic [15:0]      negseq_voltage;
    logic [15:0]      negseq_current;
  } dlvts_meas_t;

  typedef struct packed {
    logic phase1_voltage_above;
    logic phase2_voltage_above;
    logic phase3_voltage_above;
    logic phase1_current_above;
    logic phase2_current_above;
    logic phase3_current_above;
    logic dead_state_out;
    logic live_state_out;
    logic vt_fail;
  } dlvts_stat_t;

endpackage

// file: src/dlvts_hold_timer.sv
// Purpose: Persistence timer, done once run held for CYCLES edges
// Assumes: run from logic on sys_clk
// Notes:   Counter saturates; drop of run clears it
`timescale 1ns/1ns
`include "dlvts_params.svh"

module dlvts_hold_timer #(
  parameter logic [`DLVTS_TMR_W-1:0] CYCLES = 24'h000001
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic run,
  output wire logic done
);

  logic [`DLVTS_TMR_W-1:0] cnt_r;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else if (!run)
      cnt_r <= '0;
    else if (cnt_r != CYCLES)
      cnt_r <= cnt_r + 24'h000001;
  end

  assign done = (cnt_r == CYCLES);

endmodule

// file: src/dlvts_top.sv
// Purpose: Dead line detection and VT secondary circuit supervision
// Assumes: Magnitudes in 0.01 % of nominal, meas_valid per Fourier result
// Notes:   Settings over classic Wishbone; no events produced
// Overview of operation
// - Enable setting, off after reset, outputs quiet
// - Voltage threshold percent, 10 to 100, 60
// - Current threshold percent, 2 to 100, 10
// - Block input forces detection and outputs inactive
// - Per-phase voltage above threshold flags
// - Per-phase current above threshold flags
// - Dead: all voltages and currents below
// - Live: all three voltages above threshold
// - Dead and live states readable in status
// - No events generated by this block
// - Drive VT failure output for secondary faults
// - Three supervision modes: zero, negative, special
// - Zero: residual voltage high, residual current low
// - Negative: negseq voltage high, negseq current low
// - Special: residual voltage high, both currents low
// - Supervision uses live and dead states
// - Arm after 200 ms live; dead disarms
// - Fail after condition held 4 ms armed
// - Clear after 200 ms when live, condition gone
// - Dead entry: keep if 100 ms, else clear
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "dlvts_params.svh"

module dlvts_top #(
  parameter logic [`DLVTS_TMR_W-1:0] ARM_CYC   = 24'(`DLVTS_ARM_MS * (`DLVTS_CLK_HZ / 1000)),
  parameter logic [`DLVTS_TMR_W-1:0] COND_CYC  = 24'(`DLVTS_COND_MS * (`DLVTS_CLK_HZ / 1000)),
  parameter logic [`DLVTS_TMR_W-1:0] REL_CYC   = 24'(`DLVTS_REL_MS * (`DLVTS_CLK_HZ / 1000)),
  parameter logic [`DLVTS_TMR_W-1:0] LATCH_CYC = 24'(`DLVTS_LATCH_MS * (`DLVTS_CLK_HZ / 1000))
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output wire logic                 wb_ack_o,
  // Measurement front end
  input  wire logic                 meas_valid,
  input  dlvts_pkg::dlvts_meas_t    meas,
  // User logic
  input  wire logic                 block_input,
  output dlvts_pkg::dlvts_stat_t    stat_o
);

  localparam int PW = `DLVTS_PCT_W;

  // Settings
  logic                    enable_r;
  dlvts_pkg::dlvts_mode_t  mode_r;
  logic [PW-1:0]           dld_u_r;
  logic [PW-1:0]           dld_i_r;
  logic [PW-1:0]           vts_u_r;
  logic [PW-1:0]           vts_i0_r;
  logic [PW-1:0]           vts_i2_r;
  // Bus
  logic                    ack_r;
  logic                    req;
  logic                    wr_stb;
  logic [31:0]             rd_nxt;
  logic [31:0]             stat_word;
  // Detection
  logic                    func_ok;
  logic [2:0]              vflag_r;
  logic [2:0]              iflag_r;
  logic                    dead_r;
  logic                    live_r;
  logic                    dead_d_r;
  logic                    dead_rise;
  // Supervision
  logic                    vu0_r;
  logic                    vu2_r;
  logic                    vi0_r;
  logic                    vi2_r;
  logic                    vt_cond;
  logic                    armed_r;
  logic                    vt_fail_r;
  logic                    arm_done;
  logic                    cond_done;
  logic                    rel_done;
  logic                    long_done;

  // Settings range limiter
  function automatic logic [PW-1:0] clamp_pct(input logic [PW-1:0] val, input logic [PW-1:0] lo);
    logic [PW-1:0] res;
    res = val;
    if (val < lo)
      res = lo;
    else if (val > `DLVTS_PCT_MAX)
      res = `DLVTS_PCT_MAX;
    return res;
  endfunction

  // Comparator with hysteresis, magnitude in 0.01 % units
  function automatic logic above_next(input logic prev, input logic [15:0] mag, input logic [PW-1:0] pct);
    logic [23:0] m;
    logic [23:0] pick;
    logic [23:0] drop;
    m    = {8'h00, mag};
    pick = 24'({17'h00000, pct} * `DLVTS_PICK_MUL);
    drop = 24'({17'h00000, pct} * `DLVTS_DROP_MUL);
    return prev ? (m >= drop) : (m > pick);
  endfunction

  // Wishbone handshake
  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_stb   = req & wb_we_i;
  assign wb_ack_o = ack_r;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // Control register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enable_r <= 1'b0;
      mode_r   <= dlvts_pkg::DLVTS_MODE_ZERO;
    end
    else if (wr_stb && wb_adr_i == `DLVTS_ADDR_CTRL && wb_sel_i[0])
    begin
      enable_r <= wb_dat_i[`DLVTS_CTRL_EN];
      if (wb_dat_i[`DLVTS_CTRL_MODE +: 2] != 2'h3)
        mode_r <= dlvts_pkg::dlvts_mode_t'(wb_dat_i[`DLVTS_CTRL_MODE +: 2]);
    end
  end

  // Dead line thresholds
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dld_u_r <= `DLVTS_DLD_U_DEF;
      dld_i_r <= `DLVTS_DLD_I_DEF;
    end
    else if (wr_stb && wb_adr_i == `DLVTS_ADDR_DTHR)
    begin
      if (wb_sel_i[0])
        dld_u_r <= clamp_pct(wb_dat_i[`DLVTS_DTHR_U +: PW], `DLVTS_DLD_U_MIN);
      if (wb_sel_i[2])
        dld_i_r <= clamp_pct(wb_dat_i[`DLVTS_DTHR_I +: PW], `DLVTS_DLD_I_MIN);
    end
  end

  // Supervision thresholds
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vts_u_r  <= `DLVTS_VTS_U_DEF;
      vts_i0_r <= `DLVTS_VTS_I0_DEF;
      vts_i2_r <= `DLVTS_VTS_I2_DEF;
    end
    else if (wr_stb && wb_adr_i == `DLVTS_ADDR_VTHR)
    begin
      if (wb_sel_i[0])
        vts_u_r <= clamp_pct(wb_dat_i[`DLVTS_VTHR_U +: PW], `DLVTS_VTS_MIN);
      if (wb_sel_i[1])
        vts_i0_r <= clamp_pct(wb_dat_i[`DLVTS_VTHR_I0 +: PW], `DLVTS_VTS_MIN);
      if (wb_sel_i[2])
        vts_i2_r <= clamp_pct(wb_dat_i[`DLVTS_VTHR_I2 +: PW], `DLVTS_VTS_MIN);
    end
  end

  // Status word
  assign stat_word = {{`DLVTS_STAT_PAD{1'b0}}, vt_fail_r & dead_r, vt_fail_r, armed_r,
                      live_r, dead_r, iflag_r, vflag_r};

  // Read data mux
  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `DLVTS_ADDR_CTRL:
      begin
        rd_nxt[`DLVTS_CTRL_EN]        = enable_r;
        rd_nxt[`DLVTS_CTRL_MODE +: 2] = mode_r;
      end
      `DLVTS_ADDR_DTHR:
      begin
        rd_nxt[`DLVTS_DTHR_U +: PW] = dld_u_r;
        rd_nxt[`DLVTS_DTHR_I +: PW] = dld_i_r;
      end
      `DLVTS_ADDR_VTHR:
      begin
        rd_nxt[`DLVTS_VTHR_U +: PW]  = vts_u_r;
        rd_nxt[`DLVTS_VTHR_I0 +: PW] = vts_i0_r;
        rd_nxt[`DLVTS_VTHR_I2 +: PW] = vts_i2_r;
      end
      `DLVTS_ADDR_STAT: rd_nxt = stat_word;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wb_dat_o <= 32'h00000000;
    else if (req && !wb_we_i)
      wb_dat_o <= rd_nxt;
  end

  // Function operable
  assign func_ok = enable_r & ~block_input;

  // Phase comparators
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vflag_r <= 3'h0;
      iflag_r <= 3'h0;
    end
    else if (!func_ok)
    begin
      vflag_r <= 3'h0;
      iflag_r <= 3'h0;
    end
    else if (meas_valid)
    begin
      for (int k = 0; k < 3; k++)
      begin
        vflag_r[k] <= above_next(vflag_r[k], meas.phase_voltage[k], dld_u_r);
        iflag_r[k] <= above_next(iflag_r[k], meas.phase_current[k], dld_i_r);
      end
    end
  end

  // Dead and live states
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dead_r   <= 1'b0;
      live_r   <= 1'b0;
      dead_d_r <= 1'b0;
    end
    else
    begin
      dead_r   <= func_ok & ~|vflag_r & ~|iflag_r;
      live_r   <= func_ok & (&vflag_r);
      dead_d_r <= dead_r;
    end
  end

  assign dead_rise = dead_r & ~dead_d_r;

  // Sequence comparators
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vu0_r <= 1'b0;
      vu2_r <= 1'b0;
      vi0_r <= 1'b0;
      vi2_r <= 1'b0;
    end
    else if (!func_ok)
    begin
      vu0_r <= 1'b0;
      vu2_r <= 1'b0;
      vi0_r <= 1'b0;
      vi2_r <= 1'b0;
    end
    else if (meas_valid)
    begin
      vu0_r <= above_next(vu0_r, meas.residual_voltage, vts_u_r);
      vu2_r <= above_next(vu2_r, meas.negseq_voltage, vts_u_r);
      vi0_r <= above_next(vi0_r, meas.residual_current, vts_i0_r);
      vi2_r <= above_next(vi2_r, meas.negseq_current, vts_i2_r);
    end
  end

  // Mode condition
  always_comb
  begin
    case (mode_r)
      dlvts_pkg::DLVTS_MODE_ZERO:    vt_cond = vu0_r & ~vi0_r;
      dlvts_pkg::DLVTS_MODE_NEG:     vt_cond = vu2_r & ~vi2_r;
      dlvts_pkg::DLVTS_MODE_SPECIAL: vt_cond = vu0_r & ~vi0_r & ~vi2_r;
      default:                       vt_cond = 1'b0;
    endcase
  end

  // Persistence timers
  dlvts_hold_timer #(.CYCLES(ARM_CYC)) u_arm_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (live_r),
    .done    (arm_done)
  );

  dlvts_hold_timer #(.CYCLES(COND_CYC)) u_cond_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (armed_r & vt_cond),
    .done    (cond_done)
  );

  dlvts_hold_timer #(.CYCLES(REL_CYC)) u_rel_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (vt_fail_r & live_r & ~vt_cond),
    .done    (rel_done)
  );

  dlvts_hold_timer #(.CYCLES(LATCH_CYC)) u_long_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (vt_fail_r),
    .done    (long_done)
  );

  // Arming
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed_r <= 1'b0;
    else if (!func_ok || dead_r)
      armed_r <= 1'b0;
    else if (arm_done)
      armed_r <= 1'b1;
  end

  // Failure output
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      vt_fail_r <= 1'b0;
    else if (!func_ok)
      vt_fail_r <= 1'b0;
    else if (dead_rise)
      vt_fail_r <= vt_fail_r & long_done;
    else if (armed_r && cond_done)
      vt_fail_r <= 1'b1;
    else if (rel_done)
      vt_fail_r <= 1'b0;
  end

  // Outputs; levels only, nothing event-like
  assign stat_o = '{phase1_voltage_above: vflag_r[0],
                    phase2_voltage_above: vflag_r[1],
                    phase3_voltage_above: vflag_r[2],
                    phase1_current_above: iflag_r[0],
                    phase2_current_above: iflag_r[1],
                    phase3_current_above: iflag_r[2],
                    dead_state_out:       dead_r,
                    live_state_out:       live_r,
                    vt_fail:              vt_fail_r};

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !ack_r;
  endsequence

  sequence ack_pulse_s;
    ack_r ##1 !ack_r;
  endsequence

  sequence dead_entry_s;
    vt_fail_r && !dead_r ##1 dead_r;
  endsequence

  off_quiet_a: assert property (!func_ok |=> vflag_r == 3'h0 && iflag_r == 3'h0 && !vt_fail_r
                                && !armed_r) else $error("outputs active while disabled");
  dead_cause_a: assert property (dead_r |-> $past(func_ok) && $past(vflag_r) == 3'h0 && $past(iflag_r) == 3'h0)
    else $error("dead state without cause");
  live_cause_a: assert property (live_r |-> $past(func_ok) && $past(vflag_r) == 3'h7 && !dead_r)
    else $error("live state without cause");
  volt_pickup_a: assert property (func_ok && meas_valid && $rose(func_ok) == 1'b0
                                  && above_next(1'b0, meas.phase_voltage[0], dld_u_r) ##1 func_ok
                                  |-> vflag_r[0]) else $error("voltage flag missed pickup");
  curr_dropout_a: assert property (func_ok && meas_valid && iflag_r[1]
                                   && {8'h00, meas.phase_current[1]} < 24'({17'h00000, dld_i_r} * `DLVTS_DROP_MUL)
                                   |=> !iflag_r[1]) else $error("current flag missed dropout");
  curr_hold_a: assert property (func_ok && meas_valid && iflag_r[2]
                                && {8'h00, meas.phase_current[2]} >= 24'({17'h00000, dld_i_r} * `DLVTS_DROP_MUL)
                                ##1 func_ok |-> iflag_r[2]) else $error("current flag lost in band");
  fail_armed_a: assert property ($rose(vt_fail_r) |-> $past(armed_r) && $past(cond_done) && $past(vt_cond))
    else $error("failure without armed condition");
  dead_disarm_a: assert property (dead_r |=> !armed_r) else $error("armed during dead line");
  latch_keep_a: assert property (dead_entry_s ##0 (vt_fail_r && long_done && func_ok) |-> ##1 vt_fail_r)
    else $error("long failure not latched");
  latch_drop_a: assert property (dead_entry_s ##0 (!long_done && func_ok) |-> ##1 !vt_fail_r)
    else $error("short failure not reset");
  release_live_a: assert property (vt_fail_r && rel_done && !dead_rise && !cond_done |=> !vt_fail_r)
    else $error("failure not released");
  bus_ack_a: assert property (bus_req_s |=> ack_pulse_s) else $error("bad ack timing");

endmodule

// file: dv/dlvts_fe_model.sv
// Purpose: Behavioural front end, one Fourier result per period
// Assumes: Targets set by the bench on sys_clk
// Notes:   Between results the data lines show the inverse pattern
`timescale 1ns/1ns

module dlvts_fe_model #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Targets from the bench
  input  dlvts_pkg::dlvts_meas_t meas_set,
  // Front end outputs
  output logic                   meas_valid,
  output dlvts_pkg::dlvts_meas_t meas
);
  logic [3:0] tick_r;

  // Pulse and data once per period
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_r     <= 4'h0;
      meas_valid <= 1'b0;
      meas       <= '0;
    end
    else
    begin
      tick_r     <= (tick_r == 4'(PERIOD - 1)) ? 4'h0 : tick_r + 4'h1;
      meas_valid <= (tick_r == 4'h0);
      meas       <= (tick_r == 4'h0) ? meas_set : ~meas_set;
    end
  end
endmodule

// file: dv/dlvts_top_tb.sv
// Purpose: Self-checking bench of dead line detection and VT supervision
// Assumes: Short supervision counts given as parameters
// Notes:   Front end model gives a result every four cycles
`timescale 1ns/1ns

module dlvts_top_tb;
  localparam logic [23:0] ARM_C = 24'h000028;
  localparam logic [15:0] V_HI  = 16'h1b58;
  localparam logic [15:0] I_HI  = 16'h07d0;
  localparam logic [15:0] R_HI  = 16'h0fa0;
  localparam logic [15:0] Z     = 16'h0000;

  logic                   sys_clk;
  logic                   sys_rst;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic [3:0]             adr;
  logic [3:0]             sel;
  logic [31:0]            wdat;
  logic [31:0]            rdat;
  logic                   ack;
  logic                   meas_valid;
  logic                   block_input;
  dlvts_pkg::dlvts_meas_t meas_set;
  dlvts_pkg::dlvts_meas_t meas;
  dlvts_pkg::dlvts_stat_t stat_o;
  int                     mismatches;
  int                     comparisons;
  logic [31:0]            q;

  always #10 sys_clk = ~sys_clk;

  dlvts_fe_model fe (.sys_clk(sys_clk), .sys_rst(sys_rst), .meas_set(meas_set), .meas_valid(meas_valid),
    .meas(meas));

  dlvts_top #(.ARM_CYC(ARM_C), .COND_CYC(24'h000008), .REL_CYC(24'h000028), .LATCH_CYC(24'h000014)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_valid(meas_valid),
    .meas(meas), .block_input(block_input), .stat_o(stat_o));

  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("word %h expected %h", got, exp));
  endtask

  // Bounded wait for the status outputs to reach a value
  task automatic chk_st(input logic [8:0] exp);
    int n;
    for (n = 0; n < 400; n++)
    begin
      @(posedge sys_clk);
      if (stat_o === exp)
        break;
    end
    comparisons++;
    if (n == 400)
    begin
      fail($sformatf("status %b expected %b", stat_o, exp));
      report_and_stop();
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (ack === 1'b1)
        break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
    begin
      fail("bus timeout");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000, 4'hf);
    chk32(q, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic dlvts_pkg::dlvts_meas_t mk(input logic [15:0] v, i, rv, ri, nv, ni);
    mk = {{3{v}}, {3{i}}, rv, ri, nv, ni};
  endfunction

  task automatic drive(input dlvts_pkg::dlvts_meas_t m);
    @(posedge sys_clk);
    meas_set <= m;
  endtask

  task automatic t_reset();
    chk_st(9'h000);
    rd_chk(4'h0, 32'h00000000);
    rd_chk(4'h4, 32'h000a003c);
    rd_chk(4'h8, 32'h000a0a1e);
    rd_chk(4'hc, 32'h00000000);
    drive(mk(V_HI, I_HI, R_HI, Z, R_HI, Z));
    idle(12);
    chk_st(9'h000);
    rd_chk(4'h2, 32'h00000000);
    $display("test reset and off done");
  endtask

  task automatic t_regs();
    wr(4'h4, 32'h007f0005);
    rd_chk(4'h4, 32'h0064000a);
    wr(4'h4, 32'h000a003c);
    wb(1'b1, 4'h8, 32'h00ffff14, 4'h1);
    rd_chk(4'h8, 32'h000a0a14);
    wr(4'h8, 32'h000a0a1e);
    wr(4'h0, 32'h00000007);
    rd_chk(4'h0, 32'h00000001);
    wr(4'hc, 32'hffffffff);
    wr(4'h2, 32'hffffffff);
    rd_chk(4'h2, 32'h00000000);
    $display("test registers done");
  endtask

  task automatic t_flags();
    int                     k;
    dlvts_pkg::dlvts_meas_t m;
    for (k = 0; k < 3; k++)
    begin
      m = mk(Z, Z, Z, Z, Z, Z);
      m.phase_voltage[k] = V_HI;
      m.phase_current[k] = I_HI;
      drive(m);
      chk_st({3'b100 >> k, 3'b100 >> k, 3'b000});
    end
    drive(mk(16'h1771, Z, Z, Z, Z, Z));
    chk_st(9'b111_000_010);
    drive(mk(16'h16a8, Z, Z, Z, Z, Z));
    idle(12);
    chk_st(9'b111_000_010);
    drive(mk(16'h15e0, Z, Z, Z, Z, Z));
    chk_st(9'b000_000_100);
    drive(mk(16'h1770, Z, Z, Z, Z, Z));
    idle(12);
    chk_st(9'b000_000_100);
    m = mk(Z, Z, Z, Z, Z, Z);
    m.phase_current[2] = 16'h03e9;
    drive(m);
    chk_st(9'b000_001_000);
    drive(mk(V_HI, I_HI, Z, Z, Z, Z));
    chk_st(9'b111_111_010);
    @(posedge sys_clk);
    block_input <= 1'b1;
    chk_st(9'h000);
    idle(12);
    chk_st(9'h000);
    block_input <= 1'b0;
    chk_st(9'b111_111_010);
    $display("test flags done");
  endtask

  task automatic t_vts();
    int k;
    for (k = 0; k < 3; k++)
    begin
      wr(4'h0, {29'h0, 2'(k), 1'b1});
      drive(mk(Z, Z, Z, Z, Z, Z));
      chk_st(9'b000_000_100);
      drive(mk(V_HI, Z, (k == 1) ? Z : R_HI, Z, (k == 1) ? R_HI : Z, Z));
      idle(30);
      chk32({31'h0, stat_o.vt_fail}, 32'h0);
      chk_st(9'b111_000_011);
      rd_chk(4'hc, 32'h00000387);
      drive(mk(V_HI, Z, Z, Z, Z, Z));
      idle(20);
      chk32({31'h0, stat_o.vt_fail}, 32'h1);
      chk_st(9'b111_000_010);
    end
    drive(mk(Z, Z, Z, Z, Z, Z));
    chk_st(9'b000_000_100);
    drive(mk(V_HI, Z, R_HI, Z, Z, I_HI));
    idle(80);
    chk_st(9'b111_000_010);
    $display("test supervision modes done");
  endtask

  task automatic t_latch();
    wr(4'h0, 32'h00000001);
    drive(mk(Z, Z, Z, Z, Z, Z));
    chk_st(9'b000_000_100);
    drive(mk(V_HI, Z, R_HI, Z, Z, Z));
    chk_st(9'b111_000_011);
    idle(30);
    drive(mk(Z, Z, Z, Z, Z, Z));
    idle(8);
    chk_st(9'b000_000_101);
    rd_chk(4'hc, 32'h00000640);
    wr(4'h0, 32'h00000000);
    chk_st(9'h000);
    wr(4'h0, 32'h00000001);
    drive(mk(V_HI, Z, R_HI, Z, Z, Z));
    chk_st(9'b111_000_011);
    drive(mk(Z, Z, Z, Z, Z, Z));
    chk_st(9'b000_000_100);
    $display("test dead entry done");
  endtask

  initial
  begin
    sys_clk     = 1'b0;
    sys_rst     = 1'b1;
    cyc         = 1'b0;
    stb         = 1'b0;
    we          = 1'b0;
    adr         = 4'h0;
    sel         = 4'h0;
    wdat        = 32'h00000000;
    block_input = 1'b0;
    meas_set    = '0;
    mismatches  = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_flags();
    t_vts();
    t_latch();
    report_and_stop();
  end
endmodule
